/* File: hw/pwm_period_sevt.sv */
// PWM period register and special event trigger with APB slave
`timescale 1ns/1ps
`include "pwm_sevt_map.svh"
module pwm_period_sevt (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire pwm_sevt_pkg::apb_addr_t    paddr,
  input  wire pwm_sevt_pkg::apb_word_t    pwdata,
  output logic                            pready,
  output logic                            pslverr,
  output pwm_sevt_pkg::apb_word_t         prdata,
  input  wire pwm_sevt_pkg::count_value_t time_base_count,
  input  wire logic                       count_direction_status,
  output pwm_sevt_pkg::count_value_t      period_value,
  output logic                            special_event_trigger,
  output logic                            irq
);
  import pwm_sevt_pkg::*;

  sevt_match_if m ();

  count_value_t                period_ff;
  logic [15:0]                 compare_ff;
  logic [`IRQ_WIDTH-1:0]       status_ff;
  logic [`IRQ_WIDTH-1:0]       mask_ff;
  logic                        ready_ff;
  logic                        err_ff;
  apb_word_t                   rdata_ff;
  logic                        trig_ff;
  logic                        irq_ff;
  logic                        access;
  logic                        commit;
  logic                        rd_en;
  logic                        wr_en;
  logic                        wr_period;
  logic                        wr_compare;
  logic                        wr_status;
  logic                        wr_mask;
  logic                        mapped;
  logic [`IRQ_WIDTH-1:0]       irq_event;
  logic [`IRQ_WIDTH-1:0]       irq_pending;
  apb_word_t                   nxt_rdata;

  function automatic logic hit(input apb_addr_t a, input apb_addr_t off);
    hit = (a == off);
  endfunction : hit

  // True for every offset that holds a register
  function automatic logic known_addr(input apb_addr_t a);
    if (hit(a, `PERIOD_OFFSET)) begin
      known_addr = 1'b1;
    end else if (hit(a, `COMPARE_OFFSET)) begin
      known_addr = 1'b1;
    end else if (hit(a, `COUNT_OFFSET)) begin
      known_addr = 1'b1;
    end else if (hit(a, `IRQ_STATUS_OFFSET)) begin
      known_addr = 1'b1;
    end else if (hit(a, `IRQ_MASK_OFFSET)) begin
      known_addr = 1'b1;
    end else begin
      known_addr = 1'b0;
    end
  endfunction : known_addr

  // First access cycle: read data is captured, pready rises next
  assign access = psel && penable && !ready_ff;
  // Pready is high here, so writes land at this edge and no other
  assign commit = psel && penable && ready_ff;
  assign rd_en  = access && !pwrite;
  assign wr_en  = commit && pwrite;
  assign mapped = known_addr(paddr);

  assign wr_period  = wr_en && hit(paddr, `PERIOD_OFFSET);
  assign wr_compare = wr_en && hit(paddr, `COMPARE_OFFSET);
  assign wr_status  = wr_en && hit(paddr, `IRQ_STATUS_OFFSET);
  assign wr_mask    = wr_en && hit(paddr, `IRQ_MASK_OFFSET);

  // One wait state, then ready for a single cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= access;
    end
  end

  // Unmapped offsets answer with an error beside pready
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= access && !mapped;
    end
  end

  // Bits 31:15 of a period write are dropped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      period_ff <= `PERIOD_RESET;
    end else if (wr_period) begin
      period_ff <= pwdata[`VALUE_MSB:0];
    end
  end

  // Bit 15 is the direction select, bits 14:0 the compare value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      compare_ff <= `COMPARE_RESET;
    end else if (wr_compare) begin
      compare_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_ff <= '0;
    end else if (wr_mask) begin
      mask_ff <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // Only the match unit raises a status bit so far
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_TRIGGER_BIT] = m.trigger_pulse;
  end

  // Set wins over a write-one clear in the same cycle
  generate
    for (genvar i = 0; i < `IRQ_WIDTH; i++) begin : g_status
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          status_ff[i] <= 1'b0;
        end else if (irq_event[i]) begin
          status_ff[i] <= 1'b1;
        end else if (wr_status && pwdata[i]) begin
          status_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_pending = status_ff & mask_ff;

  // Unused bits of every register read as zero
  always_comb begin
    nxt_rdata = '0;
    if (hit(paddr, `PERIOD_OFFSET)) begin
      nxt_rdata[`VALUE_MSB:0] = period_ff;
    end else if (hit(paddr, `COMPARE_OFFSET)) begin
      nxt_rdata[15:0] = compare_ff;
    end else if (hit(paddr, `COUNT_OFFSET)) begin
      nxt_rdata[`TOP_BIT] = count_direction_status;
      nxt_rdata[`VALUE_MSB:0] = time_base_count;
    end else if (hit(paddr, `IRQ_STATUS_OFFSET)) begin
      nxt_rdata[`IRQ_WIDTH-1:0] = status_ff;
    end else if (hit(paddr, `IRQ_MASK_OFFSET)) begin
      nxt_rdata[`IRQ_WIDTH-1:0] = mask_ff;
    end else begin
      nxt_rdata = '0;
    end
  end

  // Captured on the first access cycle, shown beside pready
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign m.trigger_compare_value    = compare_ff[`VALUE_MSB:0];
  assign m.trigger_direction_select = compare_ff[`TOP_BIT];

  // Match unit; its pulse feeds the status bit and the trigger pin
  sevt_compare u_cmp (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .time_base_count        (time_base_count),
    .count_direction_status (count_direction_status),
    .m                      (m)
  );

  // Retimed so the trigger pin comes straight from a flip-flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= m.trigger_pulse;
    end
  end

  // Interrupt follows the status bits gated by mask_ff one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |irq_pending;
    end
  end

  assign pready                = ready_ff;
  assign pslverr               = err_ff;
  assign prdata                = rdata_ff;
  assign period_value          = period_ff;
  assign special_event_trigger = trig_ff;
  assign irq                   = irq_ff;
endmodule : pwm_period_sevt

/* File: hw/pwm_sevt_map.svh */
// Register offsets, field positions and reset values of the period block
`ifndef PWM_SEVT_MAP_SVH
`define PWM_SEVT_MAP_SVH
`define PERIOD_OFFSET     12'h000
`define COMPARE_OFFSET    12'h004
`define COUNT_OFFSET      12'h008
`define IRQ_STATUS_OFFSET 12'h00c
`define IRQ_MASK_OFFSET   12'h010
`define TOP_BIT           15
`define VALUE_MSB         14
`define PERIOD_RESET      15'h0000
`define COMPARE_RESET     16'h0000
`define IRQ_TRIGGER_BIT   0
`define IRQ_WIDTH         1
`endif

/* File: hw/pwm_sevt_pkg.sv */
// Types shared by the period and special event trigger block
package pwm_sevt_pkg;
  typedef logic [14:0] count_value_t;
  typedef logic [31:0] apb_word_t;
  typedef logic [11:0] apb_addr_t;
endpackage : pwm_sevt_pkg

/* File: hw/sevt_match_if.sv */
// Signals between the register side and the compare unit
`timescale 1ns/1ps
interface sevt_match_if;
  import pwm_sevt_pkg::*;
  count_value_t trigger_compare_value;
  logic         trigger_direction_select;
  logic         trigger_pulse;
  modport regs (output trigger_compare_value, output trigger_direction_select,
                input trigger_pulse);
  modport cmp  (input trigger_compare_value, input trigger_direction_select,
                output trigger_pulse);
endinterface : sevt_match_if

/* File: hw/sevt_compare.sv */
// Compare of running count and direction against the trigger setting
`timescale 1ns/1ps
module sevt_compare (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire pwm_sevt_pkg::count_value_t time_base_count,
  input  wire logic                       count_direction_status,
  sevt_match_if.cmp                       m
);
  import pwm_sevt_pkg::*;
  logic match_now;
  logic match_ff;
  logic pulse_ff;

  assign match_now = (time_base_count == m.trigger_compare_value)
    && (count_direction_status == m.trigger_direction_select);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= match_now;
    end
  end

  // Pulse only once per match, in the cycle after its first cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= match_now && !match_ff;
    end
  end

  assign m.trigger_pulse = pulse_ff;
endmodule : sevt_compare

/* File: bench/pwm_sevt_monitor.sv */
// Port checks of the period and special event trigger block
`timescale 1ns/1ps
module pwm_sevt_monitor (
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire pwm_sevt_pkg::apb_addr_t    paddr,
  input wire pwm_sevt_pkg::apb_word_t    pwdata,
  input wire logic                       pready,
  input wire pwm_sevt_pkg::apb_word_t    prdata,
  input wire pwm_sevt_pkg::count_value_t time_base_count,
  input wire logic                       count_direction_status,
  input wire pwm_sevt_pkg::count_value_t period_value,
  input wire logic                       special_event_trigger,
  input wire logic                       irq
);
  import pwm_sevt_pkg::*;
  logic [15:0] cmp_ff;
  logic        mask_ff;
  wire         wr = psel && penable && pready && pwrite;
  wire         match = time_base_count == cmp_ff[14:0] &&
                       count_direction_status == cmp_ff[15];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmp_ff  <= 16'h0000;
      mask_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h004) cmp_ff <= pwdata[15:0];
      if (paddr == 12'h010) mask_ff <= pwdata[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready long");
  a_period_top_zero: assert property (pready && !pwrite && paddr == 12'h000
    |-> prdata[31:15] == 17'h00000) else $error("period top bits set");
  a_period_write: assert property (wr && paddr == 12'h000
    |=> period_value == $past(pwdata[14:0])) else $error("period lost");
  a_trig_pulse: assert property (special_event_trigger
    |=> !special_event_trigger) else $error("trigger long");
  a_trig_on_match: assert property ($rose(match)
    |-> ##[1:4] special_event_trigger) else $error("trigger missed");
  a_trig_needs_match: assert property (special_event_trigger
    |-> $past(match, 2) || $past(match, 3)) else $error("trigger stray");
  a_irq_raise: assert property (special_event_trigger && mask_ff
    |-> ##[1:2] irq) else $error("irq missed");
endmodule : pwm_sevt_monitor
bind pwm_period_sevt pwm_sevt_monitor mon_u (
  .clock                  (clock),
  .rst_n                  (rst_n),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .pready                 (pready),
  .prdata                 (prdata),
  .time_base_count        (time_base_count),
  .count_direction_status (count_direction_status),
  .period_value           (period_value),
  .special_event_trigger  (special_event_trigger),
  .irq                    (irq)
);

/* File: bench/time_base_model.sv */
// Up/down time base that feeds count and direction to the block
`timescale 1ns/1ps
module time_base_model (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       run,
  input  wire pwm_sevt_pkg::count_value_t top,
  output pwm_sevt_pkg::count_value_t      count_ff,
  output logic                            dir_ff
);
  import pwm_sevt_pkg::*;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_ff <= 15'h0001;
      dir_ff   <= 1'b0;
    end else if (run) begin
      if (!dir_ff && count_ff >= top) dir_ff <= 1'b1;
      else if (dir_ff && count_ff == 15'h0000) dir_ff <= 1'b0;
      if (!dir_ff && count_ff >= top) count_ff <= count_ff - 15'h0001;
      else if (dir_ff && count_ff != 15'h0000) count_ff <= count_ff - 15'h0001;
      else count_ff <= count_ff + 15'h0001;
    end
  end
endmodule : time_base_model

/* File: bench/pwm_period_and_special_event_trigger_tb.sv */
// Self-checking bench of the period and special event trigger block
`timescale 1ns/1ps
module pwm_period_and_special_event_trigger_tb;
  import pwm_sevt_pkg::*;
  logic         clock, rst_n, psel, penable, pwrite, run, pready, pslverr;
  logic         dir, trig, irq;
  apb_addr_t    paddr;
  apb_word_t    pwdata, prdata, rd;
  count_value_t cnt, per;
  int           fail_count, cmp_count, cyc, trig_n;
  pwm_period_sevt dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .time_base_count(cnt), .count_direction_status(dir),
    .period_value(per), .special_event_trigger(trig), .irq(irq));
  time_base_model tbm_u (.clock(clock), .rst_n(rst_n), .run(run),
    .top(per), .count_ff(cnt), .dir_ff(dir));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (trig === 1'b1) trig_n++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task check(input apb_word_t seen, input apb_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input apb_addr_t a, input apb_word_t d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task test_regs;
    apb(0, 12'h000, 0); check(rd, 0);
    apb(0, 12'h004, 0); check(rd, 0);
    apb(1, 12'h000, 32'hffffffff); apb(0, 12'h000, 0);
    check(rd, 32'h00007fff);
    check({17'h0, per}, 32'h00007fff);
    apb(1, 12'h008, 32'hffffffff); apb(0, 12'h008, 0);
    check(rd, 32'h00000001);
    apb(0, 12'h020, 0); check(rd, 0); check({31'h0, pslverr}, 1);
    $display("register test done");
  endtask : test_regs
  task test_trigger;
    for (int d = 0; d < 2; d++) begin
      apb(1, 12'h010, d); apb(1, 12'h000, 10);
      apb(1, 12'h004, {16'h0, d[0], 15'h0005});
      trig_n = 0; run <= 1'b1;
      repeat (20) @(posedge clock);
      run <= 1'b0;
      repeat (6) @(posedge clock);
      check(32'(trig_n), 1);
      check({31'h0, irq}, d);
      apb(0, 12'h00c, 0); check(rd, 1);
      apb(1, 12'h00c, 1); repeat (3) @(posedge clock);
      check({31'h0, irq}, 0);
    end
    $display("trigger test done");
  endtask : test_trigger
  task test_hold;
    trig_n = 0;
    run <= 1'b1;
    repeat (12) @(posedge clock);
    run <= 1'b0;
    apb(0, 12'h008, 0);
    check(rd, 32'h00008007);
    apb(1, 12'h004, 32'h00008007);
    repeat (10) @(posedge clock);
    check(32'(trig_n), 1);
    $display("hold test done");
  endtask : test_hold
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    {rst_n, psel, penable, pwrite, run, paddr, pwdata} = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    test_regs();
    test_trigger();
    test_hold();
    final_report();
  end
endmodule : pwm_period_and_special_event_trigger_tb
